// >>> bcr_defs.vh
// Constants of the brightness calibration readout block
//------------------------------------------------------------
// Functional notes
// - Surface brightness is published as a two-byte bus object.
// - The object is sent on change, cyclically, both, or only read.
// - Factory calibration uses reflection coefficient 0.3.
// - A calibration value is mapped onto the current measurement.
// - Calibration is accepted only when calibration by telegram is set.
// - Uncalibrated telegram mode disables all brightness evaluation.
// - Uncalibrated, the object holds 0 (no send) or 7FFF.
// - A new calibration replaces the old one in non-volatile store.
// - Selecting factory calibration discards the user calibration.
// - In the walking test the blue LED shows detected motion.
// - Walking test starts after commissioning or toggles by remote.
// - Optionally the LED shows motion in normal operation too.
//------------------------------------------------------------
`ifndef BCR_DEFS_VH
`define BCR_DEFS_VH

// Register offsets
`define BCR_A_CTRL    8'h00
`define BCR_A_DELTA   8'h04
`define BCR_A_PERIOD  8'h08
`define BCR_A_STATUS  8'h0C
`define BCR_A_OBJ     8'h10
`define BCR_A_GAIN    8'h14
`define BCR_A_ISTAT   8'h18
`define BCR_A_IMASK   8'h1C

// Control fields
`define BCR_C_CALTEL  0
`define BCR_C_INVAL   1
`define BCR_C_SCHG    2
`define BCR_C_SCYC    3
`define BCR_C_WALKC   4
`define BCR_C_LEDN    5
`define BCR_C_IREN    6
`define BCR_C_FACT    7

// Interrupt fields
`define BCR_I_CALOK   0
`define BCR_I_CALBAD  1
`define BCR_I_TX      2
`define BCR_I_MOT     3

// Reset values
`define BCR_CTRL_RST  8'h00
`define BCR_DELTA_RST 16'h0032
`define BCR_PER_RST   16'h003C
`define BCR_MASK_RST  4'h0

// Gain 1/0.3 in 8.8 fixed point
`define BCR_FACT_GAIN 16'h0355
`define BCR_INVALID   16'h7FFF
`define BCR_LUX_CENTS 7'h64

// Timing
`define BCR_CLK_HZ    32'h0262_5A00
`define BCR_TICK_S    1

`endif

// >>> bcr_divider.v
// Restoring divider, one quotient bit per clock
module bcr_divider #(
  parameter NW = 34,
  parameter DW = 23
) (
  // Clock and reset
  input  wire          clk,
  input  wire          rst_b,
  // Operands
  input  wire          start,
  input  wire [NW-1:0] num,
  input  wire [DW-1:0] den,
  // Result
  output reg           busy_ff,
  output reg           done_ff,
  output reg  [NW-1:0] quo_ff
);
  localparam [5:0] NCNT = NW;
  reg  [DW-1:0] rem_ff;
  reg  [DW-1:0] den_ff;
  reg  [5:0]    cnt_ff;
  wire [DW:0]   trial = {rem_ff, quo_ff[NW-1]};
  wire          fits  = trial >= {1'b0, den_ff};
  wire [DW:0]   diff  = trial - {1'b0, den_ff};

  // Shift and subtract sequence
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
      quo_ff  <= {NW{1'b0}};
      rem_ff  <= {DW{1'b0}};
      den_ff  <= {DW{1'b0}};
      cnt_ff  <= 6'h00;
    end else begin
      done_ff <= 1'b0;
      if (start && !busy_ff) begin
        quo_ff  <= num;
        rem_ff  <= {DW{1'b0}};
        den_ff  <= den;
        cnt_ff  <= NCNT;
        busy_ff <= 1'b1;
      end else if (busy_ff) begin
        rem_ff <= fits ? diff[DW-1:0] : trial[DW-1:0];
        quo_ff <= {quo_ff[NW-2:0], fits};
        cnt_ff <= cnt_ff - 6'h01;
        if (cnt_ff == 6'h01) begin
          busy_ff <= 1'b0;
          done_ff <= 1'b1;
        end
      end
    end
  end
endmodule

// >>> bcr_dpt9.v
// Two-octet float lux encoder and decoder
`include "bcr_defs.vh"

module bcr_dpt9 (
  // Encoder side
  input  wire [15:0] enc_lux,
  output reg  [15:0] enc_val,
  // Decoder side
  input  wire [15:0] dec_val,
  output reg  [25:0] dec_cents,
  output reg         dec_neg
);
  reg     [22:0] cents;
  reg     [22:0] mant;
  reg     [3:0]  expo;
  integer        i;

  // Lux to 0.01 lux steps, smallest exponent that fits
  always @* begin
    cents = {7'h00, enc_lux} * {16'h0000, `BCR_LUX_CENTS};
    expo  = 4'h0;
    for (i = 0; i < 12; i = i + 1) begin
      if ((cents >> expo) >= 23'h00_0800) begin
        expo = expo + 4'h1;
      end
    end
    mant    = cents >> expo;
    enc_val = {1'b0, expo, mant[10:0]};
  end

  // Float to 0.01 lux steps, negatives flagged
  always @* begin
    dec_neg   = dec_val[15];
    dec_cents = {15'h0000, dec_val[10:0]} << dec_val[14:11];
  end
endmodule

// >>> bcr_readout.v
// Brightness readout with user calibration and walking test LED
//
// The address map and strobed register access are this design's own decisions.
`include "bcr_defs.vh"

module bcr_readout #(
  parameter TICK_CYC = `BCR_TICK_S * `BCR_CLK_HZ
) (
  // Clock and reset
  input  wire        clk,
  input  wire        rst_b,
  // Register port
  input  wire [7:0]  reg_addr,
  input  wire [31:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [31:0] reg_rdata_ff,
  // Sensor samples, reflected lux
  input  wire        meas_valid,
  input  wire [15:0] meas_lux,
  // Brightness object
  input  wire        obj_rd_req,
  output reg         obj_rd_ack_ff,
  output reg         obj_tx_ff,
  output reg  [15:0] obj_val_ff,
  // Calibration object
  input  wire        cal_wr,
  input  wire [15:0] cal_val,
  // Calibration store
  input  wire        nv_ok,
  input  wire [15:0] nv_gain_in,
  output reg         nv_wr_ff,
  output reg  [15:0] nv_gain_ff,
  // Commissioning, remote, motion pin
  input  wire        commission,
  input  wire        ir_test,
  input  wire        motion_pin,
  // Results
  output reg         eval_en_ff,
  output reg         led_ff,
  output reg         irq_ff
);

  //----------------------------------------------------------
  // Declarations
  //----------------------------------------------------------
  localparam [2:0] S_IDLE = 3'h1;
  localparam [2:0] S_DIV  = 3'h2;
  localparam [2:0] S_END  = 3'h4;
  localparam [31:0] TICKS = TICK_CYC;
  reg  [7:0]  ctrl_ff;
  reg  [15:0] delta_ff;
  reg  [15:0] period_ff;
  reg  [3:0]  istat_ff;
  reg  [3:0]  imask_ff;
  reg  [15:0] ugain_ff;
  reg         calok_ff;
  reg         boot_ff;
  reg  [15:0] meas_ff;
  reg  [15:0] surf_ff;
  reg  [15:0] sent_ff;
  reg  [31:0] tick_ff;
  reg  [15:0] sec_ff;
  reg         cyc_due_ff;
  reg  [2:0]  st_ff;
  reg  [2:0]  nxt_st;
  reg         walk_ff;
  reg         m1_ff;
  reg         m2_ff;
  reg         m3_ff;
  reg  [15:0] nxt_obj;
  reg         nxt_tx;
  reg  [3:0]  ev_set;
  reg  [31:0] nxt_rdata;
  wire [15:0] enc_val;
  wire [25:0] dec_cents;
  wire        dec_neg;
  wire        div_busy;
  wire        div_done;
  wire [33:0] div_quo;
  wire        caltel = ctrl_ff[`BCR_C_CALTEL];
  wire        uncal  = caltel && !calok_ff;
  wire [15:0] gain   = (caltel && calok_ff) ? ugain_ff
                                            : `BCR_FACT_GAIN;
  wire [31:0] prod   = {16'h0000, meas_lux} * {16'h0000, gain};
  wire [15:0] sdiff  = (surf_ff > sent_ff) ? surf_ff - sent_ff
                                           : sent_ff - surf_ff;
  wire        wr_ctrl = reg_wr && (reg_addr == `BCR_A_CTRL);
  wire        to_fact = wr_ctrl &&
                        (reg_wdata[`BCR_C_FACT] ||
                         (caltel && !reg_wdata[`BCR_C_CALTEL]));
  wire        cal_req = cal_wr && caltel && st_ff[0] && !div_busy;
  wire        cal_bad = dec_neg || (meas_ff == 16'h0000);
  wire        div_go  = cal_req && !cal_bad && !to_fact;
  wire [15:0] qgain   = (|div_quo[33:16]) ? 16'hFFFF
                                          : div_quo[15:0];
  wire [22:0] den_w   = {7'h00, meas_ff} * {16'h0000, `BCR_LUX_CENTS};

  //----------------------------------------------------------
  // Submodules
  //----------------------------------------------------------
  // Gain = wanted cents * 256 / (raw lux * 100)
  bcr_divider u_div (
    .clk     (clk),
    .rst_b   (rst_b),
    .start   (div_go),
    .num     ({dec_cents, 8'h00}),
    .den     (den_w),
    .busy_ff (div_busy),
    .done_ff (div_done),
    .quo_ff  (div_quo)
  );
  // Float codec for object and calibration value
  bcr_dpt9 u_codec (
    .enc_lux   (surf_ff),
    .enc_val   (enc_val),
    .dec_val   (cal_val),
    .dec_cents (dec_cents),
    .dec_neg   (dec_neg)
  );

  //----------------------------------------------------------
  // Register port
  //----------------------------------------------------------
  // Configuration writes
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_ff   <= `BCR_CTRL_RST;
      delta_ff  <= `BCR_DELTA_RST;
      period_ff <= `BCR_PER_RST;
      imask_ff  <= `BCR_MASK_RST;
    end else if (reg_wr) begin
      case (reg_addr)
        `BCR_A_CTRL:   ctrl_ff   <= {1'b0, reg_wdata[6:0]};
        `BCR_A_DELTA:  delta_ff  <= reg_wdata[15:0];
        `BCR_A_PERIOD: period_ff <= reg_wdata[15:0];
        `BCR_A_IMASK:  imask_ff  <= reg_wdata[3:0];
        default:       ctrl_ff   <= ctrl_ff;
      endcase
    end
  end
  // Read mux, unmapped reads zero
  always @* begin
    nxt_rdata = 32'h0000_0000;
    case (reg_addr)
      `BCR_A_CTRL:   nxt_rdata[7:0]  = ctrl_ff;
      `BCR_A_DELTA:  nxt_rdata[15:0] = delta_ff;
      `BCR_A_PERIOD: nxt_rdata[15:0] = period_ff;
      `BCR_A_STATUS: nxt_rdata[3:0]  = {div_busy, eval_en_ff,
                                        walk_ff, calok_ff};
      `BCR_A_OBJ:    nxt_rdata[15:0] = obj_val_ff;
      `BCR_A_GAIN:   nxt_rdata[15:0] = gain;
      `BCR_A_ISTAT:  nxt_rdata[3:0]  = istat_ff;
      `BCR_A_IMASK:  nxt_rdata[3:0]  = imask_ff;
      default:       nxt_rdata       = 32'h0000_0000;
    endcase
  end
  // Read data stand one cycle after the strobe, zero otherwise
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata_ff <= 32'h0000_0000;
    end else begin
      reg_rdata_ff <= reg_rd ? nxt_rdata : 32'h0000_0000;
    end
  end

  //----------------------------------------------------------
  // Calibration
  //----------------------------------------------------------
  // Sequence: idle, dividing, result
  always @* begin
    nxt_st = st_ff;
    case (st_ff)
      S_IDLE: begin
        if (div_go) begin
          nxt_st = S_DIV;
        end
      end
      S_DIV: begin
        if (div_done) begin
          nxt_st = S_END;
        end
      end
      S_END:   nxt_st = S_IDLE;
      default: nxt_st = S_IDLE;
    endcase
  end
  // User gain, calibrated flag and store writes
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_ff      <= S_IDLE;
      boot_ff    <= 1'b1;
      ugain_ff   <= 16'h0000;
      calok_ff   <= 1'b0;
      nv_wr_ff   <= 1'b0;
      nv_gain_ff <= 16'h0000;
    end else begin
      st_ff    <= nxt_st;
      boot_ff  <= 1'b0;
      nv_wr_ff <= 1'b0;
      if (boot_ff) begin
        // Restore a calibration kept over power loss
        if (nv_ok && (nv_gain_in != 16'h0000)) begin
          ugain_ff <= nv_gain_in;
          calok_ff <= 1'b1;
        end
      end else if (to_fact) begin
        // Back to factory, user value wiped
        ugain_ff   <= 16'h0000;
        calok_ff   <= 1'b0;
        nv_gain_ff <= 16'h0000;
        nv_wr_ff   <= 1'b1;
        st_ff      <= S_IDLE;
      end else if (st_ff[1] && div_done &&
                   (qgain != 16'h0000)) begin
        // New value replaces the old one
        ugain_ff   <= qgain;
        calok_ff   <= 1'b1;
        nv_gain_ff <= qgain;
        nv_wr_ff   <= 1'b1;
      end
    end
  end

  //----------------------------------------------------------
  // Brightness evaluation and object
  //----------------------------------------------------------
  // Raw sample and surface brightness
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meas_ff <= 16'h0000;
      surf_ff <= 16'h0000;
    end else if (meas_valid) begin
      meas_ff <= meas_lux;
      if (uncal) begin
        surf_ff <= 16'h0000;
      end else if (|prod[31:24]) begin
        surf_ff <= 16'hFFFF;
      end else begin
        surf_ff <= prod[23:8];
      end
    end
  end
  // Seconds tick and cyclic send timer
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tick_ff    <= 32'h0000_0000;
      sec_ff     <= 16'h0000;
      cyc_due_ff <= 1'b0;
    end else begin
      cyc_due_ff <= 1'b0;
      if (tick_ff >= TICKS - 32'h0000_0001) begin
        tick_ff <= 32'h0000_0000;
        if (sec_ff + 16'h0001 >= period_ff) begin
          sec_ff     <= 16'h0000;
          cyc_due_ff <= 1'b1;
        end else begin
          sec_ff <= sec_ff + 16'h0001;
        end
      end else begin
        tick_ff <= tick_ff + 32'h0000_0001;
      end
    end
  end
  // Object value and send decision
  always @* begin
    nxt_tx = 1'b0;
    if (uncal) begin
      if (ctrl_ff[`BCR_C_INVAL]) begin
        nxt_obj = `BCR_INVALID;
        nxt_tx  = cyc_due_ff && ctrl_ff[`BCR_C_SCYC];
      end else begin
        nxt_obj = 16'h0000;
      end
    end else begin
      nxt_obj = enc_val;
      if (ctrl_ff[`BCR_C_SCYC] && cyc_due_ff) begin
        nxt_tx = 1'b1;
      end
      if (ctrl_ff[`BCR_C_SCHG] && (sdiff >= delta_ff) &&
          (delta_ff != 16'h0000)) begin
        nxt_tx = 1'b1;
      end
    end
  end
  // Object register, sends and read answers
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      obj_val_ff    <= 16'h0000;
      obj_tx_ff     <= 1'b0;
      obj_rd_ack_ff <= 1'b0;
      sent_ff       <= 16'h0000;
      eval_en_ff    <= 1'b0;
    end else begin
      obj_val_ff    <= nxt_obj;
      obj_tx_ff     <= nxt_tx;
      obj_rd_ack_ff <= obj_rd_req;
      eval_en_ff    <= !uncal;
      if (nxt_tx) begin
        sent_ff <= surf_ff;
      end
    end
  end

  //----------------------------------------------------------
  // Walking test and status LED
  //----------------------------------------------------------
  // Motion pin synchroniser and edge stage
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      m1_ff <= 1'b0;
      m2_ff <= 1'b0;
      m3_ff <= 1'b0;
    end else begin
      m1_ff <= motion_pin;
      m2_ff <= m1_ff;
      m3_ff <= m2_ff;
    end
  end
  // Walking test on commissioning or remote toggle
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      walk_ff <= 1'b0;
    end else if (commission) begin
      walk_ff <= ctrl_ff[`BCR_C_WALKC];
    end else if (ir_test && ctrl_ff[`BCR_C_IREN]) begin
      walk_ff <= !walk_ff;
    end
  end
  // LED follows motion in test or when enabled
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      led_ff <= 1'b0;
    end else begin
      led_ff <= m2_ff && (walk_ff || ctrl_ff[`BCR_C_LEDN]);
    end
  end

  //----------------------------------------------------------
  // Interrupts
  //----------------------------------------------------------
  // Events of this cycle
  always @* begin
    ev_set                = 4'h0;
    ev_set[`BCR_I_CALOK]  = st_ff[1] && div_done &&
                            (qgain != 16'h0000) && !to_fact;
    ev_set[`BCR_I_CALBAD] = (cal_req && cal_bad) ||
                            (st_ff[1] && div_done &&
                             (qgain == 16'h0000));
    ev_set[`BCR_I_TX]     = nxt_tx;
    ev_set[`BCR_I_MOT]    = m2_ff && !m3_ff;
  end
  // Sticky status, write one to clear, set wins
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      istat_ff <= 4'h0;
      irq_ff   <= 1'b0;
    end else begin
      if (reg_wr && (reg_addr == `BCR_A_ISTAT)) begin
        istat_ff <= (istat_ff & ~reg_wdata[3:0]) | ev_set;
      end else begin
        istat_ff <= istat_ff | ev_set;
      end
      irq_ff <= |(istat_ff & imask_ff);
    end
  end

endmodule

// >>> bcr_checker.sv
// Concurrent checks on the brightness readout ports
module bcr_checker (
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst_b,
  // Register and sample inputs
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        cal_wr,
  input wire logic        motion_pin,
  // Object and store outputs
  input wire logic        obj_rd_req,
  input wire logic        obj_rd_ack_ff,
  input wire logic        obj_tx_ff,
  input wire logic [15:0] obj_val_ff,
  input wire logic        nv_wr_ff,
  input wire logic [15:0] nv_gain_ff,
  input wire logic        eval_en_ff,
  input wire logic        led_ff
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // Cycles since an accepted-looking calibration, busy repeats skipped
  logic [7:0] since_cal_ff;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b)
      since_cal_ff <= 8'hFF;
    else if (cal_wr && since_cal_ff > 8'h28)
      since_cal_ff <= 8'h00;
    else if (since_cal_ff != 8'hFF)
      since_cal_ff <= since_cal_ff + 8'h01;
  end
  // Factory command and the store clear it causes
  sequence s_fact_cmd;
    reg_wr && reg_addr == 8'h00 && reg_wdata[7];
  endsequence
  sequence s_nv_clear;
    nv_wr_ff && nv_gain_ff == 16'h0000;
  endsequence
  AST_OBJ_ACK: assert property (obj_rd_req |=> obj_rd_ack_ff)
    else $error("object read not answered");
  AST_ACK_CAUSE: assert property (obj_rd_ack_ff |-> $past(obj_rd_req))
    else $error("object answer without read");
  AST_NV_CAL: assert property (nv_wr_ff && nv_gain_ff != 16'h0000 |-> since_cal_ff inside {[33:37]})
    else $error("store write not timed to calibration");
  AST_NV_FACT: assert property (s_fact_cmd |-> ##[1:3] s_nv_clear)
    else $error("factory command did not clear store");
  AST_EVAL_CAL: assert property (nv_wr_ff && nv_gain_ff != 16'h0000 |-> ##[0:2] eval_en_ff)
    else $error("evaluation not enabled after calibration");
  AST_UNCAL_VAL: assert property ((!eval_en_ff)[*3] |-> obj_val_ff == 16'h0000 || obj_val_ff == 16'h7FFF)
    else $error("uncalibrated object value wrong");
  AST_UNCAL_SEND: assert property (obj_tx_ff && !eval_en_ff && !$past(eval_en_ff) |-> obj_val_ff == 16'h7FFF)
    else $error("uncalibrated send without invalid marker");
  AST_LED_IDLE: assert property ((!motion_pin)[*5] |-> !led_ff)
    else $error("indicator lit without motion");
  AST_TX_SIGN: assert property (obj_tx_ff |-> !obj_val_ff[15])
    else $error("negative brightness sent");
endmodule

bind bcr_readout bcr_checker i_bcr_checker (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .cal_wr(cal_wr), .motion_pin(motion_pin), .obj_rd_req(obj_rd_req),
  .obj_rd_ack_ff(obj_rd_ack_ff), .obj_tx_ff(obj_tx_ff), .obj_val_ff(obj_val_ff), .nv_wr_ff(nv_wr_ff),
  .nv_gain_ff(nv_gain_ff), .eval_en_ff(eval_en_ff), .led_ff(led_ff));

// >>> bcr_store_model.sv
// Non-volatile calibration store and bus listener model
module bcr_store_model (
  // Clock
  input  wire logic        clk,
  // Store port
  input  wire logic        nv_wr_ff,
  input  wire logic [15:0] nv_gain_ff,
  output logic             nv_ok,
  output logic [15:0]      nv_gain_in,
  // Bus listener
  input  wire logic        obj_tx_ff,
  output int               tx_count
);
  timeunit 1ns;
  timeprecision 1ps;
  // Store content survives the device reset
  initial begin
    nv_ok = 1'b1;
    nv_gain_in = 16'h0000;
    tx_count = 0;
  end
  always @(posedge clk) begin
    if (nv_wr_ff)
      nv_gain_in <= nv_gain_ff;
    if (obj_tx_ff)
      tx_count <= tx_count + 1;
  end
endmodule

// >>> tb_top.sv
// Self-checking bench of the brightness readout
`include "bcr_defs.vh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // Signals and instances
  // ----------------------------------------
  logic        clk = 0, rst_b = 0, reg_wr = 0, reg_rd = 0, meas_valid = 0, obj_rd_req = 0;
  logic        cal_wr = 0, commission = 0, ir_test = 0, motion_pin = 0;
  logic [7:0]  reg_addr = 0;
  logic [31:0] reg_wdata = 0, reg_rdata_ff, rdv;
  logic [15:0] meas_lux = 0, cal_val = 0, obj_val_ff, nv_gain_in, nv_gain_ff;
  logic        obj_rd_ack_ff, obj_tx_ff, nv_ok, nv_wr_ff, eval_en_ff, led_ff, irq_ff;
  int          tx_count, tx0, bad_count = 0, samples_checked = 0;

  bcr_readout #(.TICK_CYC(20)) i_bcr_readout (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff),
    .meas_valid(meas_valid), .meas_lux(meas_lux), .obj_rd_req(obj_rd_req), .obj_rd_ack_ff(obj_rd_ack_ff),
    .obj_tx_ff(obj_tx_ff), .obj_val_ff(obj_val_ff), .cal_wr(cal_wr), .cal_val(cal_val), .nv_ok(nv_ok),
    .nv_gain_in(nv_gain_in), .nv_wr_ff(nv_wr_ff), .nv_gain_ff(nv_gain_ff), .commission(commission),
    .ir_test(ir_test), .motion_pin(motion_pin), .eval_en_ff(eval_en_ff), .led_ff(led_ff), .irq_ff(irq_ff));
  bcr_store_model i_bcr_store_model (.clk(clk), .nv_wr_ff(nv_wr_ff), .nv_gain_ff(nv_gain_ff), .nv_ok(nv_ok),
    .nv_gain_in(nv_gain_in), .obj_tx_ff(obj_tx_ff), .tx_count(tx_count));

  initial forever #12.5 clk = ~clk;
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task chk(input [31:0] got, input [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task wr(input [7:0] a, input [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1;
    @(posedge clk);
    reg_wr <= 0;
  endtask
  task rd(input [7:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1;
    @(posedge clk);
    reg_rd <= 0;
    #1 rdv = reg_rdata_ff;
  endtask
  task rchk(input [7:0] a, input [31:0] e);
    rd(a);
    chk(rdv, e);
  endtask
  task smp(input [15:0] l);
    @(posedge clk);
    meas_lux <= l;
    meas_valid <= 1;
    @(posedge clk);
    meas_valid <= 0;
    repeat (4) @(posedge clk);
  endtask
  task cal(input [15:0] v);
    @(posedge clk);
    cal_val <= v;
    cal_wr <= 1;
    @(posedge clk);
    cal_wr <= 0;
  endtask
  // Two-octet float to lux
  function real lux(input [15:0] v);
    return v[10:0] * (2.0 ** v[14:11]) / 100.0;
  endfunction
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_regs;
    rchk(`BCR_A_CTRL, 0);
    rchk(`BCR_A_DELTA, 32'h0000_0032);
    rchk(`BCR_A_PERIOD, 32'h0000_003C);
    rchk(`BCR_A_GAIN, 32'h0000_0355);
    rchk(`BCR_A_IMASK, 0);
    rchk(8'h20, 0);
    rchk(`BCR_A_STATUS, 32'h0000_0004);
    $display("done regs");
  endtask
  task t_factory;
    smp(300);
    chk(lux(obj_val_ff) >= 990.0 && lux(obj_val_ff) <= 1010.0, 1);
    @(posedge clk) obj_rd_req <= 1;
    @(posedge clk) obj_rd_req <= 0;
    #1 chk(obj_rd_ack_ff, 1);
    $display("done factory");
  endtask
  task t_change;
    wr(`BCR_A_CTRL, 32'h0000_0004);
    wr(`BCR_A_IMASK, 32'h0000_0004);
    // Let the send caused by the old sent value land first
    repeat (2) @(posedge clk);
    tx0 = tx_count;
    smp(600);
    smp(605);
    smp(700);
    chk(tx_count - tx0, 2);
    chk(irq_ff, 1);
    wr(`BCR_A_ISTAT, 32'h0000_0004);
    repeat (2) @(posedge clk);
    chk(irq_ff, 0);
    wr(`BCR_A_CTRL, 32'h0000_0008);
    wr(`BCR_A_PERIOD, 1);
    tx0 = tx_count;
    repeat (100) @(posedge clk);
    chk(tx_count - tx0 >= 4 && tx_count - tx0 <= 6, 1);
    $display("done sending");
  endtask
  task t_uncal;
    wr(`BCR_A_CTRL, 32'h0000_000B);
    repeat (5) @(posedge clk);
    chk(eval_en_ff, 0);
    chk(obj_val_ff, 32'h0000_7FFF);
    tx0 = tx_count;
    repeat (60) @(posedge clk);
    chk(tx_count > tx0, 1);
    wr(`BCR_A_CTRL, 32'h0000_0009);
    // Let a cyclic send launched before the write land before counting starts
    repeat (2) @(posedge clk);
    tx0 = tx_count;
    smp(300);
    repeat (60) @(posedge clk);
    chk(obj_val_ff, 0);
    chk(tx_count - tx0, 0);
    $display("done uncalibrated");
  endtask
  task t_cal;
    smp(200);
    cal(16'h2E1A);
    repeat (4) @(posedge clk);
    cal(16'h3000);
    repeat (45) @(posedge clk);
    rchk(`BCR_A_GAIN, 32'h0000_027F);
    chk(nv_gain_in, 32'h0000_027F);
    rchk(`BCR_A_STATUS, 32'h0000_0005);
    smp(200);
    chk(lux(obj_val_ff) >= 495.0 && lux(obj_val_ff) <= 505.0, 1);
    cal(16'h8E1A);
    repeat (3) @(posedge clk);
    rd(`BCR_A_ISTAT);
    chk(rdv[1:0], 3);
    @(posedge clk) rst_b <= 0;
    repeat (3) @(posedge clk);
    rst_b <= 1;
    wr(`BCR_A_CTRL, 1);
    repeat (3) @(posedge clk);
    chk(eval_en_ff, 1);
    rchk(`BCR_A_GAIN, 32'h0000_027F);
    $display("done calibration");
  endtask
  task t_fact;
    wr(`BCR_A_CTRL, 32'h0000_0080);
    repeat (3) @(posedge clk);
    chk(nv_gain_in, 0);
    rchk(`BCR_A_GAIN, 32'h0000_0355);
    cal(16'h2E1A);
    repeat (45) @(posedge clk);
    chk(nv_gain_in, 0);
    wr(`BCR_A_CTRL, 1);
    repeat (3) @(posedge clk);
    chk(eval_en_ff, 0);
    $display("done factory reset");
  endtask
  task t_led;
    wr(`BCR_A_CTRL, 32'h0000_0040);
    motion_pin <= 1;
    repeat (6) @(posedge clk);
    chk(led_ff, 0);
    @(posedge clk) ir_test <= 1;
    @(posedge clk) ir_test <= 0;
    repeat (6) @(posedge clk);
    chk(led_ff, 1);
    @(posedge clk) ir_test <= 1;
    @(posedge clk) ir_test <= 0;
    repeat (6) @(posedge clk);
    chk(led_ff, 0);
    wr(`BCR_A_CTRL, 32'h0000_0060);
    repeat (6) @(posedge clk);
    chk(led_ff, 1);
    motion_pin <= 0;
    repeat (6) @(posedge clk);
    chk(led_ff, 0);
    wr(`BCR_A_CTRL, 32'h0000_0010);
    @(posedge clk) commission <= 1;
    @(posedge clk) commission <= 0;
    repeat (3) @(posedge clk);
    rd(`BCR_A_STATUS);
    chk(rdv[1], 1);
    $display("done indicator");
  endtask
  // ----------------------------------------
  // Run control
  // ----------------------------------------
  task finish_test;
    $display("checked %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge clk);
    rst_b <= 1;
    t_regs;
    t_factory;
    t_change;
    t_uncal;
    t_cal;
    t_fact;
    t_led;
    finish_test;
  end
  // Watchdog far beyond the expected run
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    finish_test;
  end
endmodule
